// file: rtl/mic_pkg.sv
// Constants and types for the module interrupt controller
package mic_pkg;
   // Register byte addresses
   localparam logic [7:0] MIC_OFF_CONFIG = 8'h00;
   localparam logic [7:0] MIC_OFF_PENDING = 8'h04;
   localparam logic [7:0] MIC_OFF_MASK = 8'h08;
   localparam logic [7:0] MIC_OFF_INSERVICE = 8'h0c;
   localparam logic [7:0] MIC_OFF_STATUS = 8'h10;
   // Config field positions (24-bit config register)
   localparam int MIC_CFG_SPREAD = 0;
   localparam int MIC_CFG_VB_LO = 5;
   localparam int MIC_CFG_TOP_LO = 8;
   localparam int MIC_CFG_LVL_LO = 13;
   localparam int MIC_CFG_SLOT_LO = 16;
   localparam logic [23:0] MIC_CFG_WMASK = 24'hffffe1;
   localparam logic [23:0] MIC_CFG_RESET = 24'h000000;
   localparam logic [4:0] MIC_TOP_NONE = 5'h1f;
   localparam logic [7:0] MIC_VEC_UNINIT = 8'h0f;
   localparam logic [4:0] MIC_SRC_ERROR = 5'h00;
   // Sources that hold their own event register (serial channels)
   localparam logic [31:0] MIC_EVENT_SRC = 32'h78000000;
   // Implemented source positions; the rest read as zero
   localparam logic [31:0] MIC_VALID_SRC = 32'hfff6defe;
   localparam logic [2:0] MIC_LVL_OFF = 3'h0;
   localparam int MIC_CH_LO = 27;
   localparam logic [1:0] MIC_RESP_OKAY = 2'h0;
   localparam logic [1:0] MIC_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic valid;
      logic [7:0] vector;
   } mic_ack_type;

   typedef enum logic [1:0] {
      MIC_IDLE = 2'b00,
      MIC_BUSY = 2'b01,
      MIC_RESP = 2'b11
   } mic_bus_state_type;
endpackage

// file: rtl/mic_irq_controller.sv
// Module interrupt controller with AXI4-Lite register access
// How it works
// - Top-priority field promotes one source; 11111 none
// - Vector is base bits above five source bits
// - Vector 0F until vector base written
// - Spread bit groups or spreads serial channels
// - Source event sets its pending bit
// - Acknowledge clears pending, except event-register sources
// - Event sources stay pending while events set
// - Pending: write one clears, zero keeps
// - Error vector sets no pending bit
// - Channel bit positions never move
// - Mask zero blocks request, pending still sets
// - Unmask lets pending request proceed again
// - Masked in flight, nothing else: error vector
// - Acknowledge sets source in-service bit
// - In-service: write one clears, zero keeps
// - Error vector sets no in-service; unused zero
// - Request only above highest in-service priority
// - Reset clears pending, mask, in-service
// - Level field: zero disables, seven nonmaskable
// - Slot fields pick channel per slot
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module mic_irq_controller
   import mic_pkg::*;
(
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   // Sources: pulse events and event-register summaries
   input wire logic [31:0] I_SRC_EVENT,
   input wire logic [31:0] I_SRC_EVENT_LEVEL,
   // Core side
   input wire logic I_IACK,
   output mic_pkg::mic_ack_type O_ACK,
   output logic [2:0] O_IRQ_LEVEL,
   output logic O_IRQ,
   // AXI4-Lite slave
   input wire logic [7:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [7:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY
);
   import mic_pkg::*;

   logic [23:0] config_r;
   logic vb_written_r;
   logic [31:0] pending_r;
   logic [31:0] mask_r;
   logic [31:0] inservice_r;
   logic [31:0] ev_sync1_r, ev_sync2_r, ev_sync3_r;
   logic [31:0] lvl_sync1_r, lvl_sync2_r, lvl_sync3_r;
   logic [31:0] ev_seen_r;
   logic [31:0] ev_stable_r;
   logic [31:0] lvl_stable_r;
   logic [31:0] ev_rise;

   // Three-stage synchronisers; second and third must agree
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         ev_sync1_r <= '0;
         ev_sync2_r <= '0;
         ev_sync3_r <= '0;
         lvl_sync1_r <= '0;
         lvl_sync2_r <= '0;
         lvl_sync3_r <= '0;
      end else begin
         ev_sync1_r <= I_SRC_EVENT;
         ev_sync2_r <= ev_sync1_r;
         ev_sync3_r <= ev_sync2_r;
         lvl_sync1_r <= I_SRC_EVENT_LEVEL;
         lvl_sync2_r <= lvl_sync1_r;
         lvl_sync3_r <= lvl_sync2_r;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_filt
         always_ff @(posedge I_CLK) begin
            if (!I_RESET_N) begin
               ev_stable_r[g] <= 1'b0;
               lvl_stable_r[g] <= 1'b0;
            end else begin
               if (ev_sync2_r[g] == ev_sync3_r[g]) begin
                  ev_stable_r[g] <= ev_sync3_r[g];
               end
               if (lvl_sync2_r[g] == lvl_sync3_r[g]) begin
                  lvl_stable_r[g] <= lvl_sync3_r[g];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         ev_seen_r <= '0;
      end else begin
         ev_seen_r <= ev_stable_r;
      end
   end
   assign ev_rise = ev_stable_r & ~ev_seen_r;

   // Priority order: rank 0 is highest, entry is source bit index
   logic [1:0] slot [4];
   logic [4:0] top_src;
   logic [4:0] order [32];
   logic [4:0] base_order [32];
   logic [4:0] chan_bit [4];

   assign top_src = config_r[MIC_CFG_TOP_LO +: 5];
   generate
      for (g = 0; g < 4; g++) begin : g_slot
         // Slot a is the lowest field
         assign slot[g] = config_r[MIC_CFG_SLOT_LO + 2 * g +: 2];
         // Channel one sits at bit 30, four at bit 27
         assign chan_bit[g] = 5'(MIC_CH_LO + 3 - int'(slot[g]));
      end
   endgenerate

   // Non-channel sources in vector order, highest first
   localparam logic [4:0] OTHERS [28] = '{
      5'h1f, 5'h1a, 5'h19, 5'h18, 5'h17, 5'h16, 5'h15, 5'h14, 5'h13, 5'h12,
      5'h11, 5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08,
      5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};

   always_comb begin
      int k;
      int c;
      k = 0;
      c = 0;
      for (int r = 0; r < 32; r++) begin
         base_order[r] = MIC_SRC_ERROR;
      end
      if (!config_r[MIC_CFG_SPREAD]) begin
         // Grouped: four channels first, slot order a..d
         for (int r = 0; r < 4; r++) begin
            base_order[r] = chan_bit[r];
         end
         for (int r = 4; r < 32; r++) begin
            base_order[r] = OTHERS[r - 4];
         end
      end else begin
         // Spread: one channel after every few other sources
         for (int r = 0; r < 32; r++) begin
            if ((r % 8 == 1) && c < 4) begin
               base_order[r] = chan_bit[c];
               c = c + 1;
            end else if (k < 28) begin
               base_order[r] = OTHERS[k];
               k = k + 1;
            end
         end
      end
      // Promote top source to rank 0, sources ranked above its old place shift down one
      for (int r = 0; r < 32; r++) begin
         order[r] = base_order[r];
      end
      if (top_src != MIC_TOP_NONE) begin
         order[0] = top_src;
         k = 1;
         for (int r = 0; r < 32; r++) begin
            if (base_order[r] != top_src && k < 32) begin
               order[k] = base_order[r];
               k = k + 1;
            end
         end
      end
   end

   // Rank of highest in-service source, and winner search
   logic [31:0] eligible;
   logic found;
   logic [4:0] win_src;
   logic [5:0] isr_rank;
   logic [5:0] win_rank;

   always_comb begin
      isr_rank = 6'd32;
      for (int r = 31; r >= 0; r--) begin
         if (inservice_r[order[r]] && MIC_VALID_SRC[order[r]]) begin
            isr_rank = 6'(r);
         end
      end
   end

   // Masked sources pend but never request
   assign eligible = pending_r & mask_r & MIC_VALID_SRC;

   always_comb begin
      found = 1'b0;
      win_src = MIC_SRC_ERROR;
      win_rank = 6'd32;
      for (int r = 31; r >= 0; r--) begin
         // Only ranks above the highest in-service win
         if (eligible[order[r]] && 6'(r) < isr_rank) begin
            found = 1'b1;
            win_src = order[r];
            win_rank = 6'(r);
         end
      end
   end

   // Request to core at programmed level
   logic [2:0] level;
   assign level = config_r[MIC_CFG_LVL_LO +: 3];
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         O_IRQ <= 1'b0;
         O_IRQ_LEVEL <= MIC_LVL_OFF;
      end else begin
         O_IRQ <= found && (level != MIC_LVL_OFF);
         O_IRQ_LEVEL <= (found && level != MIC_LVL_OFF) ? level : MIC_LVL_OFF;
      end
   end

   // Acknowledge: deliver winner or unmaskable error vector
   logic [7:0] vec_nxt;
   always_comb begin
      if (!vb_written_r) begin
         vec_nxt = MIC_VEC_UNINIT;
      end else begin
         vec_nxt = {config_r[MIC_CFG_VB_LO +: 3], found ? win_src : MIC_SRC_ERROR};
      end
   end
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         O_ACK <= '0;
      end else begin
         O_ACK.valid <= I_IACK;
         if (I_IACK) begin
            O_ACK.vector <= vec_nxt;
         end
      end
   end
   logic ack_hit;
   assign ack_hit = I_IACK && found;

   // AXI4-Lite slave: one write and one read at a time
   mic_bus_state_type wr_state_r;
   logic aw_got_r, w_got_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_do;
   assign O_AWREADY = (wr_state_r == MIC_IDLE) && !aw_got_r;
   assign O_WREADY = (wr_state_r == MIC_IDLE) && !w_got_r;
   assign wr_do = (wr_state_r == MIC_BUSY);
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         wr_state_r <= MIC_IDLE;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         O_BVALID <= 1'b0;
         O_BRESP <= MIC_RESP_OKAY;
      end else begin
         case (wr_state_r)
            MIC_IDLE: begin
               if (I_AWVALID && O_AWREADY) begin
                  aw_got_r <= 1'b1;
                  awaddr_r <= I_AWADDR;
               end
               if (I_WVALID && O_WREADY) begin
                  w_got_r <= 1'b1;
                  wdata_r <= I_WDATA;
                  wstrb_r <= I_WSTRB;
               end
               if ((aw_got_r || I_AWVALID) && (w_got_r || I_WVALID)) begin
                  wr_state_r <= MIC_BUSY;
               end
            end
            MIC_BUSY: begin
               O_BVALID <= 1'b1;
               O_BRESP <= (awaddr_r[7:2] > MIC_OFF_STATUS[7:2] || awaddr_r[1:0] != 2'b00)
                  ? MIC_RESP_SLVERR : MIC_RESP_OKAY;
               wr_state_r <= MIC_RESP;
            end
            MIC_RESP: begin
               if (I_BREADY) begin
                  O_BVALID <= 1'b0;
                  aw_got_r <= 1'b0;
                  w_got_r <= 1'b0;
                  wr_state_r <= MIC_IDLE;
               end
            end
            default: wr_state_r <= MIC_IDLE;
         endcase
      end
   end

   logic [31:0] wmask;
   generate
      for (g = 0; g < 4; g++) begin : g_strb
         assign wmask[8 * g +: 8] = {8{wstrb_r[g]}};
      end
   endgenerate
   logic wr_cfg, wr_pend, wr_mask, wr_isr;
   assign wr_cfg = wr_do && awaddr_r == MIC_OFF_CONFIG;
   assign wr_pend = wr_do && awaddr_r == MIC_OFF_PENDING;
   assign wr_mask = wr_do && awaddr_r == MIC_OFF_MASK;
   assign wr_isr = wr_do && awaddr_r == MIC_OFF_INSERVICE;

   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         config_r <= MIC_CFG_RESET;
         vb_written_r <= 1'b0;
      end else if (wr_cfg) begin
         config_r <= (config_r & ~(wmask[23:0] & MIC_CFG_WMASK))
            | (wdata_r[23:0] & wmask[23:0] & MIC_CFG_WMASK);
         if (wstrb_r[0]) begin
            vb_written_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         mask_r <= '0;
      end else if (wr_mask) begin
         mask_r <= ((mask_r & ~wmask) | (wdata_r & wmask)) & MIC_VALID_SRC;
      end
   end

   // Pending: set beats clear; error vector touches nothing
   logic [31:0] pend_clr, pend_set, ack_one;
   assign ack_one = ack_hit ? (32'h1 << win_src) : '0;
   assign pend_clr = (wr_pend ? (wdata_r & wmask) : '0)
      | (ack_one & ~MIC_EVENT_SRC);
   assign pend_set = (ev_rise & ~MIC_EVENT_SRC)
      | (lvl_stable_r & MIC_EVENT_SRC);
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         pending_r <= '0;
      end else begin
         pending_r <= ((pending_r & ~pend_clr) | pend_set) & MIC_VALID_SRC;
      end
   end

   // In-service: ack sets, write-one clears, set wins
   logic [31:0] isr_clr;
   assign isr_clr = wr_isr ? (wdata_r & wmask) : '0;
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         inservice_r <= '0;
      end else begin
         inservice_r <= ((inservice_r & ~isr_clr) | ack_one) & MIC_VALID_SRC;
      end
   end

   // Read channel
   logic [31:0] rd_mux;
   always_comb begin
      case (I_ARADDR)
         MIC_OFF_CONFIG: rd_mux = {8'h00, config_r};
         MIC_OFF_PENDING: rd_mux = pending_r;
         MIC_OFF_MASK: rd_mux = mask_r;
         MIC_OFF_INSERVICE: rd_mux = inservice_r;
         MIC_OFF_STATUS: rd_mux = {24'h000000, found, vb_written_r, 1'b0, win_src};
         default: rd_mux = '0;
      endcase
   end
   assign O_ARREADY = !O_RVALID;
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         O_RVALID <= 1'b0;
         O_RDATA <= '0;
         O_RRESP <= MIC_RESP_OKAY;
      end else if (O_RVALID) begin
         if (I_RREADY) begin
            O_RVALID <= 1'b0;
         end
      end else if (I_ARVALID) begin
         O_RVALID <= 1'b1;
         O_RDATA <= rd_mux;
         O_RRESP <= (I_ARADDR[7:2] > MIC_OFF_STATUS[7:2] || I_ARADDR[1:0] != 2'b00)
            ? MIC_RESP_SLVERR : MIC_RESP_OKAY;
      end
   end
endmodule // mic_irq_controller

// file: sim/mic_core_model.sv
// Core-side model that runs acknowledge cycles on command
`timescale 1ns/1ns
module mic_core_model (
   // Clock and command
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic i_slow,
   // Acknowledge strobe
   output logic o_iack
);
   int cnt = 0;
   initial o_iack = 1'b0;
   // Any vector is taken, the error vector included
   always @(posedge i_clk) begin
      o_iack <= 1'b0;
      if (i_go) begin
         cnt <= i_slow ? 4 : 1;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1) begin
         o_iack <= 1'b1;
         cnt <= 0;
      end
   end
endmodule // mic_core_model

// file: sim/mic_irq_controller_sva.sv
// Port checker for the module interrupt controller
`timescale 1ns/1ns
module mic_irq_sva
   import mic_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic I_IACK,
   input mic_pkg::mic_ack_type O_ACK,
   input wire logic [2:0] O_IRQ_LEVEL,
   input wire logic O_IRQ,
   input wire logic [7:0] I_AWADDR,
   input wire logic I_AWVALID,
   input wire logic O_AWREADY,
   input wire logic [3:0] I_WSTRB,
   input wire logic [7:0] I_ARADDR,
   input wire logic I_ARVALID,
   input wire logic O_ARREADY,
   input wire logic [31:0] O_RDATA,
   input wire logic [1:0] O_RRESP,
   input wire logic O_RVALID
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   logic base_r;
   // Assumes write data is offered with its address
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         base_r <= 1'b0;
      end else if (I_AWVALID && O_AWREADY && I_AWADDR == MIC_OFF_CONFIG && I_WSTRB[0]) begin
         base_r <= 1'b1;
      end
   end
   sequence s_bad_rd;
      ##1 O_RVALID && O_RRESP == MIC_RESP_SLVERR && O_RDATA == 32'h0;
   endsequence
   sequence s_quiet;
      !O_IRQ [*3];
   endsequence
   AST_ACK_NEXT: assert property (I_IACK |=> O_ACK.valid)
      else $error("no vector after acknowledge");
   AST_ACK_ONLY: assert property (!I_IACK |=> !O_ACK.valid)
      else $error("vector without acknowledge");
   AST_VEC_HOLD: assert property (!O_ACK.valid |-> $stable(O_ACK.vector))
      else $error("vector moved between acknowledges");
   AST_VEC_UNINIT: assert property (O_ACK.valid && !base_r |-> O_ACK.vector == MIC_VEC_UNINIT)
      else $error("composed vector before base written");
   AST_LVL_OFF: assert property (!O_IRQ |-> O_IRQ_LEVEL == MIC_LVL_OFF)
      else $error("level shown without request");
   AST_LVL_ON: assert property (O_IRQ |-> O_IRQ_LEVEL != MIC_LVL_OFF)
      else $error("request at level zero");
   AST_RD_BAD: assert property (I_ARVALID && O_ARREADY && I_ARADDR > MIC_OFF_STATUS |-> s_bad_rd)
      else $error("unmapped read not refused");
   AST_RST_QUIET: assert property ($rose(I_RESET_N) |-> s_quiet)
      else $error("request right after reset");
endmodule // mic_irq_sva
bind mic_irq_controller mic_irq_sva i_sva (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
   .I_IACK(I_IACK), .O_ACK(O_ACK), .O_IRQ_LEVEL(O_IRQ_LEVEL), .O_IRQ(O_IRQ),
   .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WSTRB(I_WSTRB),
   .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
   .O_RRESP(O_RRESP), .O_RVALID(O_RVALID));

// file: sim/testbench.sv
// Self-checking bench for the module interrupt controller
`timescale 1ns/1ns
module testbench;
   import mic_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, slow = 1'b0, iack;
   logic [31:0] src = '0, lvl = '0, wdata = '0, rdata, rng = 32'h78ff;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [3:0] wstrb = 4'hf;
   logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic awrdy, wrdy, bvalid, arrdy, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [2:0] irq_lvl;
   mic_ack_type ack;
   int errors = 0, n_checks = 0;
   logic [31:0] q_vec[$], q_rd[$];
   always #5 clk = ~clk;
   mic_irq_controller i_dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_SRC_EVENT(src),
      .I_SRC_EVENT_LEVEL(lvl), .I_IACK(iack), .O_ACK(ack), .O_IRQ_LEVEL(irq_lvl),
      .O_IRQ(irq), .I_AWADDR(awaddr), .I_AWVALID(awv), .O_AWREADY(awrdy),
      .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(bresp),
      .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv),
      .O_ARREADY(arrdy), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
      .I_RREADY(rready));
   mic_core_model i_core (.i_clk(clk), .i_go(go), .i_slow(slow), .o_iack(iack));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Results are paired with the oldest note
   always @(posedge clk) begin
      if (ack.valid === 1'b1) check("vector", {24'h0, ack.vector}, q_vec.pop_front());
      if (rvalid === 1'b1 && rready) check("rdata", rdata, q_rd.pop_front());
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      logic ta, tw;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         ta = awv && !awrdy;
         tw = wv && !wrdy;
         if (!ta) awv <= 1'b0;
         if (!tw) wv <= 1'b0;
      end while (ta || tw);
      do @(posedge clk); while (!bvalid);
      check("bresp", {30'h0, bresp}, {30'h0, MIC_RESP_OKAY});
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q_rd.push_back(e);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arrdy);
      arv <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic take(input logic [7:0] v, input logic s);
      q_vec.push_back({24'h0, v});
      slow <= s;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do @(posedge clk); while (!ack.valid);
      @(posedge clk);
   endtask
   // Sources need a clean rising edge through the synchroniser
   task automatic fire(input logic [31:0] b);
      src <= b;
      repeat (3) @(posedge clk);
      src <= '0;
      repeat (6) @(posedge clk);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(MIC_OFF_PENDING, 0);
      rd(MIC_OFF_MASK, 0);
      rd(MIC_OFF_INSERVICE, 0);
      rd(8'h14, 0);
      $display("reset test done");
      wr(MIC_OFF_MASK, 32'h880);
      wr(MIC_OFF_CONFIG, 32'h9f00, 4'h6);
      fire(32'h800);
      take(MIC_VEC_UNINIT, 1'b0);
      rd(MIC_OFF_PENDING, 0);
      rd(MIC_OFF_INSERVICE, 32'h800);
      wr(MIC_OFF_INSERVICE, 32'h800);
      rd(MIC_OFF_INSERVICE, 0);
      $display("uninit vector test done");
      wr(MIC_OFF_CONFIG, 32'h939fa0);
      fire(32'h880);
      take(8'hab, 1'b1);
      repeat (2) @(posedge clk);
      check("irq", {31'h0, irq}, 0);
      wr(MIC_OFF_INSERVICE, 32'h800);
      take(8'ha7, 1'b0);
      wr(MIC_OFF_INSERVICE, 32'h80);
      wr(MIC_OFF_CONFIG, 32'h9387a0);
      fire(32'h880);
      take(8'ha7, 1'b0);
      wr(MIC_OFF_INSERVICE, 32'h80);
      take(8'hab, 1'b0);
      wr(MIC_OFF_INSERVICE, 32'h800);
      wr(MIC_OFF_CONFIG, 32'h939fa0);
      $display("priority test done");
      fire(32'h800);
      wr(MIC_OFF_MASK, 32'h80);
      take(8'ha0, 1'b0);
      rd(MIC_OFF_PENDING, 32'h800);
      rd(MIC_OFF_INSERVICE, 0);
      wr(MIC_OFF_MASK, 32'h880);
      take(8'hab, 1'b0);
      wr(MIC_OFF_INSERVICE, 32'h800);
      wr(MIC_OFF_MASK, 0);
      fire(32'h880);
      check("irq", {31'h0, irq}, 0);
      wr(MIC_OFF_PENDING, 0);
      rd(MIC_OFF_PENDING, 32'h880);
      wr(MIC_OFF_PENDING, 32'h80);
      rd(MIC_OFF_PENDING, 32'h800);
      wr(MIC_OFF_PENDING, 32'h800);
      $display("mask test done");
      wr(MIC_OFF_MASK, 32'h48000000);
      // Channels pend from their event-summary level, not from pulses
      lvl <= 32'h48000000;
      repeat (6) @(posedge clk);
      take(8'hbb, 1'b0);
      rd(MIC_OFF_PENDING, 32'h48000000);
      lvl <= 32'h40000000;
      repeat (6) @(posedge clk);
      wr(MIC_OFF_PENDING, 32'h08000000);
      wr(MIC_OFF_INSERVICE, 32'h08000000);
      take(8'hbe, 1'b0);
      wr(MIC_OFF_INSERVICE, 32'h40000000);
      take(8'hbe, 1'b1);
      lvl <= '0;
      repeat (6) @(posedge clk);
      wr(MIC_OFF_PENDING, 32'h40000000);
      wr(MIC_OFF_INSERVICE, 32'h40000000);
      rd(MIC_OFF_PENDING, 0);
      $display("channel test done");
      // Spread: slot b channel falls below source 1a
      wr(MIC_OFF_MASK, 32'h44000000);
      wr(MIC_OFF_CONFIG, 32'h939fa1);
      lvl <= 32'h40000000;
      fire(32'h04000000);
      check("irq_lvl", {29'h0, irq_lvl}, 32'h4);
      take(8'hba, 1'b0);
      wr(MIC_OFF_INSERVICE, 32'h04000000);
      take(8'hbe, 1'b0);
      lvl <= '0;
      repeat (6) @(posedge clk);
      wr(MIC_OFF_PENDING, 32'h40000000);
      wr(MIC_OFF_INSERVICE, 32'h40000000);
      wr(MIC_OFF_CONFIG, 32'h939fa0);
      rd(MIC_OFF_PENDING, 0);
      $display("spread test done");
      for (int i = 0; i < 4; i++) begin
         rng = xs(rng);
         wr(MIC_OFF_MASK, rng);
         rd(MIC_OFF_MASK, rng & MIC_VALID_SRC);
      end
      $display("random mask test done");
      end_of_test();
   end
endmodule // testbench
